// [hdl/jbel_pkg.sv]
// Package for the JTAG bootloader entry link: instruction codes, buffer
// layout, shift widths and the CPU-side register bundles.
// Assumes a single 40 MHz system clock and a host-driven TCK.
package jbel_pkg;
   localparam int IR_W = 3;
   localparam logic [2:0] IR_SYSPROG = 3'h4;
   localparam logic [2:0] IR_DEBUG = 3'h2;
   localparam logic [2:0] IR_BYPASS = 3'h7;
   localparam int PB_W = 3;
   localparam int PB_ENABLE_BIT = 0;
   localparam int PB_SRC_LSB = 1;
   localparam logic [2:0] PB_RESET = 3'h0;
   localparam logic [1:0] SRC_JTAG = 2'h0;
   localparam logic [1:0] SRC_UART = 2'h1;
   localparam int DW_W = 10;
   localparam int DW_DATA_LSB = 2;
   localparam logic [1:0] ST_BUSY = 2'h2;
   localparam logic [1:0] ST_VALID = 2'h3;
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 8;

   typedef enum logic [1:0] {
      JBEL_BOOT_APP,
      JBEL_BOOT_UART,
      JBEL_BOOT_JTAG
   } jbel_boot_t;

   typedef struct packed {
      logic [2:0] prog_buffer;
      logic transmit_complete;
   } jbel_flags_t;

   typedef struct packed {
      logic flag_we;
      logic [2:0] flag_wdata;
      logic hold_we;
      logic [7:0] hold_wdata;
   } jbel_cpu_wr_t;
endpackage

// [hdl/jbel_fifo.sv]
// Small synchronous FIFO in flip-flops with valid/ready on both sides.
// Assumes the same clock and synchronous reset as the link logic.
`timescale 1ns/1ps
module jbel_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   logic [AW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];

   always_ff @(posedge clock) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule

// [hdl/jbel_link.sv]
// TAP-side bootloader entry: IR, system-programming buffer, debug shift path.
// Assumes TCK/TMS/TDI/reset_n arrive asynchronously and are oversampled
// by the 40 MHz clock; TCK must stay well below clock/4.
`timescale 1ns/1ps
// Summary of operation
// - Core held while reset low; TAP runs.
// - IR code 100b selects system programming.
// - Update-IR selects 3-bit data path.
// - Instruction held until new IR or TLR.
// - 3-bit path loads programming buffer.
// - Bit 0 is programming enable flag.
// - Bits 2:1 select source: 00 JTAG, 01 UART.
// - Boot target from enable, source, lock.
// - Buffer mirrored in CPU read/write flag register.
// - Buffer cleared by power-on or TLR.
// - JTAG loader mode disables debug machines.
// - Debug instruction opens 10-bit shift path in JTAG loader mode only.
// - Update-DR falling TCK swaps data and holding.
// - Update-DR clears transmit complete.
// - Firmware sets transmit complete and holding data.
// - Status 10 busy, 11 valid.
// - UART loader frames 8N1.
// - Lock set at power-on, cleared by match.
module jbel_link
   import jbel_pkg::*;
(
   // System
   input wire logic clock,
   input wire logic reset,
   // Pins
   input wire logic reset_n_pin,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   // Core control
   output logic core_hold,
   output jbel_boot_t boot_target,
   output logic debug_machines_off,
   // CPU flag and data access
   input wire jbel_cpu_wr_t cpu_wr,
   output jbel_flags_t debug_flag_reg,
   input wire logic password_match,
   input wire logic password_lock_set,
   output logic password_lock,
   // Received bytes toward the ROM loader
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic rx_full
);
   typedef enum logic [3:0] {
      S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR,
      S_EX2_DR, S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR,
      S_PA_IR, S_EX2_IR, S_UPD_IR
   } jbel_tap_t;

   function automatic jbel_tap_t tap_next(input jbel_tap_t s,
                                          input logic m);
      case (s)
         S_TLR: tap_next = m ? S_TLR : S_RTI;
         S_RTI: tap_next = m ? S_SEL_DR : S_RTI;
         S_SEL_DR: tap_next = m ? S_SEL_IR : S_CAP_DR;
         S_CAP_DR: tap_next = m ? S_EX1_DR : S_SH_DR;
         S_SH_DR: tap_next = m ? S_EX1_DR : S_SH_DR;
         S_EX1_DR: tap_next = m ? S_UPD_DR : S_PA_DR;
         S_PA_DR: tap_next = m ? S_EX2_DR : S_PA_DR;
         S_EX2_DR: tap_next = m ? S_UPD_DR : S_SH_DR;
         S_UPD_DR: tap_next = m ? S_SEL_DR : S_RTI;
         S_SEL_IR: tap_next = m ? S_TLR : S_CAP_IR;
         S_CAP_IR: tap_next = m ? S_EX1_IR : S_SH_IR;
         S_SH_IR: tap_next = m ? S_EX1_IR : S_SH_IR;
         S_EX1_IR: tap_next = m ? S_UPD_IR : S_PA_IR;
         S_PA_IR: tap_next = m ? S_EX2_IR : S_PA_IR;
         S_EX2_IR: tap_next = m ? S_UPD_IR : S_SH_IR;
         S_UPD_IR: tap_next = m ? S_SEL_DR : S_RTI;
         default: tap_next = S_TLR;
      endcase
   endfunction

   // Two-flop synchronisers; only stage two is read
   logic [3:0] sy1_q, sy2_q;
   logic tck_d1_q;
   always_ff @(posedge clock) begin
      if (reset) begin
         sy1_q <= 4'h0;
         sy2_q <= 4'h0;
         tck_d1_q <= 1'b0;
      end else begin
         sy1_q <= {reset_n_pin, tck, tms, tdi};
         sy2_q <= sy1_q;
         tck_d1_q <= sy2_q[2];
      end
   end
   wire rst_n_s = sy2_q[3];
   wire tck_s = sy2_q[2];
   wire tms_s = sy2_q[1];
   wire tdi_s = sy2_q[0];
   wire tck_rise = tck_s && !tck_d1_q;
   wire tck_fall = !tck_s && tck_d1_q;

   jbel_tap_t tap_q;
   logic [2:0] ir_sh_q, ir_q;
   logic [2:0] pb_sh_q, pb_q;
   logic [9:0] dw_sh_q;
   logic [7:0] hold_q;
   logic txc_q, lock_q, tdo_q, tdo_oe_q, push_q;
   logic [7:0] push_data_q;
   logic fifo_ready;

   wire in_sysprog = (ir_q == IR_SYSPROG);
   wire in_debug = (ir_q == IR_DEBUG);
   wire jtag_loader = pb_q[PB_ENABLE_BIT] &&
      (pb_q[PB_SRC_LSB +: 2] == SRC_JTAG);
   wire [1:0] status_bits = txc_q ? ST_VALID : ST_BUSY;
   wire at_upd_dr = (tap_q == S_UPD_DR) && tck_fall;
   wire dbg_active = in_debug && jtag_loader;

   // TAP controller and IR shift advanced on rising TCK; IR loaded on falling TCK
   always_ff @(posedge clock) begin
      if (reset) begin
         tap_q <= S_TLR;
         ir_sh_q <= 3'h0;
         ir_q <= IR_BYPASS;
      end else if (tck_rise) begin
         tap_q <= tap_next(tap_q, tms_s);
         if (tap_q == S_CAP_IR) begin
            ir_sh_q <= 3'h1;
         end else if (tap_q == S_SH_IR) begin
            ir_sh_q <= {tdi_s, ir_sh_q[2:1]};
         end
      end else if (tck_fall) begin
         if (tap_q == S_TLR) begin
            ir_q <= IR_BYPASS;
         end else if (tap_q == S_UPD_IR) begin
            ir_q <= ir_sh_q;
         end
      end
   end

   // Data shift paths: 3-bit buffer path and 10-bit debug word
   always_ff @(posedge clock) begin
      if (reset) begin
         pb_sh_q <= 3'h0;
         dw_sh_q <= 10'h000;
      end else if (tck_rise) begin
         if (tap_q == S_CAP_DR && in_sysprog) begin
            pb_sh_q <= pb_q;
         end else if (tap_q == S_SH_DR && in_sysprog) begin
            pb_sh_q <= {tdi_s, pb_sh_q[2:1]};
         end else if (tap_q == S_CAP_DR && dbg_active) begin
            dw_sh_q[1:0] <= status_bits;
         end else if (tap_q == S_SH_DR && dbg_active) begin
            dw_sh_q <= {tdi_s, dw_sh_q[9:1]};
         end
      end else if (at_upd_dr && dbg_active) begin
         dw_sh_q <= {hold_q, status_bits};
      end
   end

   // Programming buffer, CPU mirror, transmit complete, holding register
   always_ff @(posedge clock) begin
      if (reset || (tap_q == S_TLR)) begin
         pb_q <= PB_RESET;
      end else if (at_upd_dr && in_sysprog) begin
         pb_q <= pb_sh_q;
      end else if (cpu_wr.flag_we) begin
         pb_q <= cpu_wr.flag_wdata;
      end
   end

   // Firmware set wins over the hardware clear so no output byte is lost
   always_ff @(posedge clock) begin
      if (reset) begin
         txc_q <= 1'b0;
         hold_q <= 8'h00;
      end else begin
         if (cpu_wr.hold_we) begin
            hold_q <= cpu_wr.hold_wdata;
            txc_q <= 1'b1;
         end else if (at_upd_dr && dbg_active) begin
            txc_q <= 1'b0;
         end
      end
   end

   // Received byte into the FIFO at the same transfer point
   always_ff @(posedge clock) begin
      if (reset) begin
         push_q <= 1'b0;
         push_data_q <= 8'h00;
      end else begin
         push_q <= at_upd_dr && dbg_active && fifo_ready;
         push_data_q <= dw_sh_q[DW_DATA_LSB +: 8];
      end
   end

   // Password lock: set by power-on, cleared by match; set has priority
   always_ff @(posedge clock) begin
      if (reset) begin
         lock_q <= 1'b1;
      end else if (password_lock_set) begin
         lock_q <= 1'b1;
      end else if (password_match) begin
         lock_q <= 1'b0;
      end
   end

   // TDO changes on falling TCK
   always_ff @(posedge clock) begin
      if (reset) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe_q <= (tap_q == S_SH_DR) || (tap_q == S_SH_IR);
         if (tap_q == S_SH_IR) begin
            tdo_q <= ir_sh_q[0];
         end else if (in_sysprog) begin
            tdo_q <= pb_sh_q[0];
         end else if (dbg_active) begin
            tdo_q <= dw_sh_q[0];
         end else begin
            tdo_q <= tdi_s;
         end
      end
   end

   // Bytes handed on are 8 bits, the loader's serial frame width
   jbel_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
      .clock(clock),
      .reset(reset),
      .in_valid(push_q),
      .in_ready(fifo_ready),
      .in_data(push_data_q),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   assign tdo = tdo_q;
   assign tdo_oe = tdo_oe_q;
   assign core_hold = !rst_n_s;
   assign debug_machines_off = jtag_loader;
   assign boot_target = pb_q[PB_ENABLE_BIT] ?
      ((pb_q[PB_SRC_LSB +: 2] == SRC_UART) ? JBEL_BOOT_UART :
      JBEL_BOOT_JTAG) :
      (lock_q ? JBEL_BOOT_APP : JBEL_BOOT_UART);
   assign debug_flag_reg = '{prog_buffer: pb_q, transmit_complete: txc_q};
   assign password_lock = lock_q;
   assign rx_full = !fifo_ready;

   // Assertions
   property p_tlr_clear;
      @(posedge clock) disable iff (reset)
      (tap_q == S_TLR) |=> (pb_q == PB_RESET);
   endproperty
   a_tlr_clear: assert property (p_tlr_clear)
      else $error("buffer not cleared in TLR");

   property p_txc_clear;
      @(posedge clock) disable iff (reset)
      (at_upd_dr && dbg_active && !cpu_wr.hold_we) |=> !txc_q;
   endproperty
   a_txc_clear: assert property (p_txc_clear)
      else $error("transmit complete not cleared");

   property p_txc_set;
      @(posedge clock) disable iff (reset)
      cpu_wr.hold_we |=> txc_q && (hold_q == $past(cpu_wr.hold_wdata));
   endproperty
   a_txc_set: assert property (p_txc_set)
      else $error("firmware write not taken");

   property p_swap;
      @(posedge clock) disable iff (reset)
      (at_upd_dr && dbg_active) |=> (dw_sh_q[9:2] == $past(hold_q));
   endproperty
   a_swap: assert property (p_swap)
      else $error("holding byte not loaded");

   property p_status;
      @(posedge clock) disable iff (reset)
      (tck_rise && tap_q == S_CAP_DR && dbg_active) |=>
         dw_sh_q[1] && (dw_sh_q[0] == $past(txc_q));
   endproperty
   a_status: assert property (p_status)
      else $error("bad status bits");

   property p_dbg_off;
      @(posedge clock) disable iff (reset)
      (pb_q == 3'h1) |-> debug_machines_off;
   endproperty
   a_dbg_off: assert property (p_dbg_off)
      else $error("debug machines not disabled");

   property p_boot;
      @(posedge clock) disable iff (reset)
      !pb_q[0] |-> (boot_target == (lock_q ? JBEL_BOOT_APP : JBEL_BOOT_UART));
   endproperty
   a_boot: assert property (p_boot)
      else $error("wrong boot target");

   property p_ir_load;
      @(posedge clock) disable iff (reset)
      (tck_fall && tap_q == S_UPD_IR) |=> (ir_q == $past(ir_sh_q));
   endproperty
   a_ir_load: assert property (p_ir_load)
      else $error("IR not updated");

   property p_lock;
      @(posedge clock) disable iff (reset)
      (password_match && !password_lock_set) |=> !password_lock;
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock not cleared");

   property p_oe_shift;
      @(posedge clock) disable iff (reset)
      (tck_fall && tap_q == S_SH_DR) |=> tdo_oe;
   endproperty
   a_oe_shift: assert property (p_oe_shift)
      else $error("TDO not driven in shift");

   property p_pb_load;
      @(posedge clock) disable iff (reset)
      (at_upd_dr && in_sysprog) |=> (pb_q == $past(pb_sh_q));
   endproperty
   a_pb_load: assert property (p_pb_load)
      else $error("buffer not loaded at update");

   property p_push;
      @(posedge clock) disable iff (reset)
      (at_upd_dr && dbg_active && fifo_ready) |=>
         push_q && (push_data_q == $past(dw_sh_q[DW_DATA_LSB +: 8]));
   endproperty
   a_push: assert property (p_push)
      else $error("received byte not pushed");

   c_sysprog: cover property (@(posedge clock) disable iff (reset)
      at_upd_dr && in_sysprog);
   c_loader: cover property (@(posedge clock) disable iff (reset)
      at_upd_dr && dbg_active && txc_q);
   c_full: cover property (@(posedge clock) disable iff (reset) rx_full);
endmodule

// [testbench/jbel_host.sv]
// JTAG host model: drives TCK, TMS and TDI, samples TDO.
// Assumes the bench clock; TCK is 8 clocks (200 ns) and idles low.
`timescale 1ns/1ps
module jbel_host (
   // Clock
   input wire logic clock,
   // TAP pins
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // TDO is sampled late in the high phase, well after it settles
   task automatic cyc(input logic m, input logic d, output logic o);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge clock);
      tck <= 1'b1;
      repeat (4) @(posedge clock);
      o = tdo;
      tck <= 1'b0;
   endtask
   // From idle: one IR or DR scan of n bits, back to idle
   task automatic scan(input logic ir, input int n, input logic [9:0] din,
                       output logic [9:0] dout);
      logic o;
      dout = 10'h000;
      cyc(1'b1, 1'b0, o);
      if (ir)
         cyc(1'b1, 1'b0, o);
      cyc(1'b0, 1'b0, o);
      cyc(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++) begin
         cyc(i == n - 1, din[i], o);
         dout[i] = o;
      end
      cyc(1'b1, 1'b0, o);
      cyc(1'b0, 1'b0, o);
   endtask
   task automatic tlr();
      logic o;
      repeat (5) cyc(1'b1, 1'b0, o);
      cyc(1'b0, 1'b0, o);
   endtask
endmodule

// [testbench/tb_jtag_bootloader_entry_link.sv]
// Self-checking bench for the bootloader entry link.
// Assumes jbel_host drives the TAP; the bench plays CPU and loader.
`timescale 1ns/1ps
module tb_jtag_bootloader_entry_link
   import jbel_pkg::*;
;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic reset_n_pin = 1'b0;
   logic tck, tms, tdi, tdo, tdo_oe, core_hold, dbg_off;
   jbel_boot_t boot;
   jbel_cpu_wr_t cpu_wr = '0;
   jbel_flags_t flags;
   logic pw_match = 1'b0;
   logic pw_set = 1'b0;
   logic pw_lock, rx_valid, rx_full;
   logic rx_ready = 1'b0;
   logic [7:0] rx_data, h;
   logic [9:0] so;
   logic [7:0] q[$];
   logic [2:0] pb;
   int error_cnt = 0;
   int n_checks = 0;
   int cycles = 0;
   int unsigned r;
   always #12.5 clock = ~clock;
   jbel_link i_dut (.clock(clock), .reset(reset), .reset_n_pin(reset_n_pin),
      .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
      .core_hold(core_hold), .boot_target(boot),
      .debug_machines_off(dbg_off), .cpu_wr(cpu_wr),
      .debug_flag_reg(flags), .password_match(pw_match),
      .password_lock_set(pw_set), .password_lock(pw_lock),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .rx_full(rx_full));
   jbel_host i_host (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo));
   task automatic test_done();
      if (error_cnt == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Whole run is about 2200 clocks
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic chk(input logic [9:0] got, input logic [9:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   function automatic jbel_boot_t exp_boot(input logic [2:0] b,
                                           input logic lk);
      if (b[PB_ENABLE_BIT])
         return b[2:1] == SRC_UART ? JBEL_BOOT_UART : JBEL_BOOT_JTAG;
      return lk ? JBEL_BOOT_APP : JBEL_BOOT_UART;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic cpu(input logic fw, input logic [2:0] fd, input logic hw,
                      input logic [7:0] hd);
      cpu_wr <= '{fw, fd, hw, hd};
      tick(1);
      cpu_wr <= '0;
      tick(2);
   endtask
   task automatic pw(input logic m, input logic s);
      pw_match <= m;
      pw_set <= s;
      tick(1);
      pw_match <= 1'b0;
      pw_set <= 1'b0;
      tick(2);
   endtask
   task automatic dbg(input logic [7:0] d);
      i_host.scan(1'b0, DW_W, {d, 2'b00}, so);
      q.push_back(d);
   endtask
   // Loader side stalls at random while draining
   task automatic drain();
      for (int k = 0; k < 200 && q.size() > 0; k++) begin
         rx_ready <= 1'($urandom);
         tick(1);
         if (rx_valid === 1'b1 && rx_ready === 1'b1)
            chk(10'(rx_data), 10'(q.pop_front()), "rx byte");
      end
      rx_ready <= 1'b0;
      tick(3);
      chk(10'(q.size()), 10'h000, "rx count");
      chk(10'(rx_valid), 10'h000, "rx empty");
   endtask
   initial begin
      r = $urandom(73);
      tick(10);
      reset <= 1'b0;
      tick(4);
      chk(10'(core_hold), 10'h001, "core hold");
      chk(10'(pw_lock), 10'h001, "lock reset");
      chk(10'(flags), 10'h000, "flags reset");
      i_host.tlr();
      i_host.scan(1'b1, IR_W, 10'(IR_SYSPROG), so);
      chk(10'(so[2:0]), 10'h001, "ir capture");
      for (int v = 0; v < 8; v++) begin
         pb = 3'(v);
         i_host.scan(1'b0, PB_W, 10'(pb), so);
         chk(10'(so[2:0]), 10'(v > 0 ? v - 1 : 0), "capture");
         chk(10'(flags.prog_buffer), 10'(pb), "buffer");
         chk(10'(dbg_off), 10'(pb == 3'b001), "dbg off");
         chk(10'(boot), 10'(exp_boot(pb, 1'b1)), "boot");
      end
      i_host.tlr();
      tick(4);
      chk(10'(flags), 10'h000, "tlr clear");
      i_host.scan(1'b0, PB_W, 10'h001, so);
      chk(10'(flags), 10'h000, "bypass");
      chk(10'(tdo_oe), 10'h000, "tdo idle");
      cpu(1'b1, 3'h3, 1'b0, 8'h00);
      chk(10'(flags.prog_buffer), 10'h003, "cpu write");
      chk(10'(boot), 10'(JBEL_BOOT_UART), "boot cpu");
      pw(1'b1, 1'b0);
      chk(10'(pw_lock), 10'h000, "lock clear");
      cpu(1'b1, 3'h0, 1'b0, 8'h00);
      chk(10'(boot), 10'(exp_boot(3'h0, 1'b0)), "boot unlocked");
      pw(1'b1, 1'b1);
      chk(10'(pw_lock), 10'h001, "lock set");
      chk(10'(boot), 10'(JBEL_BOOT_APP), "boot locked");
      cpu(1'b1, 3'h1, 1'b0, 8'h00);
      chk(10'(dbg_off), 10'h001, "jtag mode");
      i_host.scan(1'b1, IR_W, 10'(IR_DEBUG), so);
      h = 8'($urandom);
      cpu(1'b0, 3'h0, 1'b1, h);
      chk(10'(flags.transmit_complete), 10'h001, "txc set");
      dbg(8'($urandom));
      chk(10'(so[1:0]), 10'(ST_VALID), "status valid");
      tick(4);
      chk(10'(flags.transmit_complete), 10'h000, "txc clear");
      dbg(8'($urandom));
      chk(so, {h, ST_BUSY}, "hold out");
      drain();
      for (int k = 0; k < FIFO_D; k++)
         dbg(8'($urandom));
      i_host.scan(1'b0, DW_W, 10'h3FC, so);
      chk(10'(rx_full), 10'h001, "fifo full");
      drain();
      reset_n_pin <= 1'b1;
      tick(5);
      chk(10'(core_hold), 10'h000, "core run");
      reset <= 1'b1;
      tick(2);
      reset <= 1'b0;
      tick(4);
      chk(10'(flags), 10'h000, "flags reset 2");
      chk(10'(pw_lock), 10'h001, "lock reset 2");
      test_done();
   end
endmodule
